/* irms_cfg.svh */
// Offsets, field positions, reset values and coding constants for the
// input reference monitor and selector. Definitions only.
`ifndef IRMS_CFG_SVH
`define IRMS_CFG_SVH

`define IRMS_NUM_IN 6
`define IRMS_NUM_LOOP 3

`define IRMS_ADR_CTRL 8'h00
`define IRMS_ADR_LIMITS 8'h04
`define IRMS_ADR_ALLOW 8'h08
`define IRMS_ADR_RANK 8'h0c
`define IRMS_ADR_CHOICE 8'h10
`define IRMS_ADR_ALARMS 8'h14
`define IRMS_ADR_OFFS_LO 8'h18
`define IRMS_ADR_OFFS_HI 8'h1c
`define IRMS_ADR_VALID 8'h20
`define IRMS_ADR_CHANGE 8'h24
`define IRMS_ADR_FAIL 8'h28
`define IRMS_ADR_INDIC 8'h2c
`define IRMS_ADR_LOSMAP 8'h30

`define IRMS_CTRL_REFSRC 0
`define IRMS_CTRL_MISSCHK 1
`define IRMS_CTRL_REVERT1 2
`define IRMS_CTRL_REVERT2 3
`define IRMS_CTRL_NOISEWIN 4
`define IRMS_CTRL_RST 5'h00
`define IRMS_LIMITS_RST 20'h00000
`define IRMS_ALLOW_RST 6'h3f
`define IRMS_RANK_RST 24'h000000
`define IRMS_CHOICE_RST 12'h000
`define IRMS_LOSMAP_RST 24'h000000

`define IRMS_CODE_AUTO 4'h0
`define IRMS_CODE_F1 4'h3
`define IRMS_CODE_F4 4'h6
`define IRMS_CODE_F5 4'h9
`define IRMS_CODE_F6 4'ha

`endif

/* irms_pkg.sv */
// Types shared by the input reference monitor and selector.
// Expects irms_cfg.svh for numeric constants.
package irms_pkg;

   // Per-input status from the activity, lock and edge monitors
   typedef struct packed {
      logic dead;
      logic lock_timeout;
      logic miss_two;
      logic [11:0] off_sys;
      logic [11:0] off_loop;
   } irms_in_s;

   typedef enum logic [2:0] {
      IRMS_AUTO = 3'b001,
      IRMS_FORCED = 3'b010,
      IRMS_RESV = 3'b100
   } irms_mode_e;

endpackage

/* irms_top.sv */
// Input reference monitor and per-loop reference selector, Wishbone slave.
// Assumes one 25 MHz clock, synchronous inputs, offsets given in ppm.
//
// How it works
// - One bit picks system or first-loop monitor reference
// - Hard and soft monitors, 8-bit limit fields each
// - Threshold ppm is (nibble plus one) times factor
// - Hard alarm sets above reject, clears below accept
// - Soft alarm has same hysteresis, own limits
// - Hard alarm disqualifies; soft alarm never does
// - Offset value times factor gives ppm offset
// - Choice codes: auto, forced one to six
// - Forced choice ignores all quality results
// - Auto considers only inputs whose allow bit is zero
// - Auto picks highest rank among qualified inputs
// - Loops one, two need all five validity checks
// - Miss check enabled: selected input misses under two
// - Loop three ignores lock alarms for validity
// - Validity toggle sets sticky change flag, interrupts
// - Selected input going invalid sets failure flag
// - Policy bit for loops one, two; three revertive
// - Revertive follows best qualified input
// - Non-revertive switches only when current disqualified
// - Indicator shows selection; equals top ranked in auto mode when revertive
// - Mapped loss pin high disqualifies the input
// - Dead alarm disqualifies input for all loops
// - Lock alarm disqualifies input for loops one, two
//
// Local design decisions: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`include "irms_cfg.svh"

module irms_top
(
   input wire logic clock,
   input wire logic srst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire irms_pkg::irms_in_s [5:0] in_stat,
   input wire logic [3:0] los_pins,
   output logic [11:0] active_input_indicator,
   output logic [11:0] top_ranked_usable_input,
   output logic irq
);

   logic [4:0] ctrl_reg;
   logic [19:0] limits_reg;
   logic [5:0] input_allow_mask;
   logic [23:0] input_rank;
   logic [11:0] loop_input_choice;
   logic [23:0] los_map_reg;
   logic [5:0] input_hard_offset_alarm;
   logic [5:0] input_soft_offset_alarm;
   logic [7:0] offset_value_reg [6];
   logic [5:0] valid_reg [3];
   logic [5:0] change_flag_reg [3];
   logic [2:0] chosen_ref_failure_flag;
   logic [2:0] sel_reg [3];
   logic [2:0] sel_next [3];
   logic [2:0] top_now [3];
   logic [5:0] valid_now [3];
   logic [5:0] qual_now [3];
   logic [11:0] off_now [6];
   logic [31:0] rdata;
   logic wr_go;
   logic rd_go;
   logic [31:0] clr_chg;
   logic [31:0] clr_fail;
   irms_pkg::irms_mode_e mode_now [3];

   logic [7:0] hard_monitor_limits;
   logic [7:0] soft_monitor_limits;
   logic [3:0] ppm_scale_factor;
   logic monitor_ref_source_sel;
   logic cycle_miss_check_en;
   assign hard_monitor_limits = limits_reg[7:0];
   assign soft_monitor_limits = limits_reg[15:8];
   assign ppm_scale_factor = limits_reg[19:16];
   assign monitor_ref_source_sel = ctrl_reg[`IRMS_CTRL_REFSRC];
   assign cycle_miss_check_en = ctrl_reg[`IRMS_CTRL_MISSCHK];

   function automatic logic [8:0] thr_ppm(input logic [3:0] nib, input logic [3:0] fac);
      thr_ppm = (9'(nib) + 9'h001) * 9'(fac);
   endfunction

   function automatic logic [7:0] offs_val(input logic [11:0] ppm, input logic [3:0] fac);
      logic [11:0] q;
      q = (fac == 4'h0) ? 12'h000 : ppm / 12'(fac);
      offs_val = (q > 12'h0ff) ? 8'hff : q[7:0];
   endfunction

   function automatic irms_pkg::irms_mode_e decode_mode(input logic [3:0] code);
      if (code == `IRMS_CODE_AUTO)
         decode_mode = irms_pkg::IRMS_AUTO;
      else if ((code >= `IRMS_CODE_F1 && code <= `IRMS_CODE_F4) ||
               code == `IRMS_CODE_F5 || code == `IRMS_CODE_F6)
         decode_mode = irms_pkg::IRMS_FORCED;
      else
         decode_mode = irms_pkg::IRMS_RESV;
   endfunction

   function automatic logic [2:0] forced_idx(input logic [3:0] code);
      if (code >= `IRMS_CODE_F1 && code <= `IRMS_CODE_F4)
         forced_idx = 3'(code - 4'h2);
      else if (code == `IRMS_CODE_F5 || code == `IRMS_CODE_F6)
         forced_idx = 3'(code - 4'h4);
      else
         forced_idx = 3'h0;
   endfunction

   function automatic logic bit_at(input logic [5:0] v, input logic [2:0] idx);
      bit_at = (idx != 3'h0 && idx <= 3'h6) ? v[3'(idx - 3'h1)] : 1'b0;
   endfunction

   function automatic logic [2:0] pick_top(input logic [5:0] q, input logic [23:0] rk);
      logic [3:0] best;
      best = 4'h0;
      pick_top = 3'h0;
      for (int i = 0; i < 6; i++)
      begin
         if (q[i] && (pick_top == 3'h0 || rk[4*i +: 4] > best))
         begin
            pick_top = 3'(i + 1);
            best = rk[4*i +: 4];
         end
      end
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] sel);
      for (int b = 0; b < 4; b++)
         merge[8*b +: 8] = sel[b] ? d[8*b +: 8] : old[8*b +: 8];
   endfunction

   // Offsets against the chosen monitor reference
   always_comb
   begin
      for (int i = 0; i < 6; i++)
         off_now[i] = monitor_ref_source_sel ? in_stat[i].off_loop : in_stat[i].off_sys;
   end

   // Per-loop validity, qualification and best candidate
   always_comb
   begin
      for (int l = 0; l < 3; l++)
      begin
         mode_now[l] = decode_mode(loop_input_choice[4*l +: 4]);
         for (int i = 0; i < 6; i++)
         begin
            valid_now[l][i] = !in_stat[i].dead && !input_hard_offset_alarm[i]
                              && !(|(los_map_reg[4*i +: 4] & los_pins));
            if (l < 2)
               valid_now[l][i] = valid_now[l][i] && !in_stat[i].lock_timeout
                                 && !(cycle_miss_check_en && sel_reg[l] == 3'(i + 1)
                                      && in_stat[i].miss_two);
         end
         qual_now[l] = valid_now[l] & ~input_allow_mask;
         top_now[l] = pick_top(qual_now[l], input_rank);
      end
   end

   // Selection policy, one instance of logic per loop
   always_comb
   begin
      for (int l = 0; l < 3; l++)
      begin
         sel_next[l] = sel_reg[l];
         unique case (mode_now[l])
            irms_pkg::IRMS_FORCED: sel_next[l] = forced_idx(loop_input_choice[4*l +: 4]);
            irms_pkg::IRMS_AUTO:
            begin
               // Loop three has no policy bit and always reverts
               if ((l == 2) || ctrl_reg[`IRMS_CTRL_REVERT1 + l]
                   || !bit_at(qual_now[l], sel_reg[l]))
                  sel_next[l] = top_now[l];
            end
            irms_pkg::IRMS_RESV: sel_next[l] = 3'h0;
         endcase
      end
   end

   always_ff @(posedge clock)
   begin
      for (int l = 0; l < 3; l++)
      begin
         if (srst)
         begin
            sel_reg[l] <= 3'h0;
            valid_reg[l] <= 6'h00;
         end
         else
         begin
            sel_reg[l] <= sel_next[l];
            valid_reg[l] <= valid_now[l];
         end
      end
   end

   // Frequency monitors with hysteresis
   always_ff @(posedge clock)
   begin
      for (int i = 0; i < 6; i++)
      begin
         if (srst)
         begin
            input_hard_offset_alarm[i] <= 1'b0;
            input_soft_offset_alarm[i] <= 1'b0;
            offset_value_reg[i] <= 8'h00;
         end
         else
         begin
            if (off_now[i] > 12'(thr_ppm(hard_monitor_limits[3:0], ppm_scale_factor)))
               input_hard_offset_alarm[i] <= 1'b1;
            else if (off_now[i] < 12'(thr_ppm(hard_monitor_limits[7:4], ppm_scale_factor)))
               input_hard_offset_alarm[i] <= 1'b0;
            if (off_now[i] > 12'(thr_ppm(soft_monitor_limits[3:0], ppm_scale_factor)))
               input_soft_offset_alarm[i] <= 1'b1;
            else if (off_now[i] < 12'(thr_ppm(soft_monitor_limits[7:4], ppm_scale_factor)))
               input_soft_offset_alarm[i] <= 1'b0;
            offset_value_reg[i] <= offs_val(off_now[i], ppm_scale_factor);
         end
      end
   end

   // Bus handshake: one wait state, ack lasts exactly one cycle
   // Writes land on the ack edge, so a master that drops early writes nothing
   assign wr_go = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i;
   assign rd_go = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign clr_chg = (wr_go && wb_adr_i == `IRMS_ADR_CHANGE) ?
                    merge(32'h0, wb_dat_i, wb_sel_i) : 32'h0;
   assign clr_fail = (wr_go && wb_adr_i == `IRMS_ADR_FAIL) ?
                     merge(32'h0, wb_dat_i, wb_sel_i) : 32'h0;

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end
      else
      begin
         wb_ack_o <= rd_go;
         if (rd_go && !wb_we_i)
            wb_dat_o <= rdata;
      end
   end

   // Control registers
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         ctrl_reg <= `IRMS_CTRL_RST;
         limits_reg <= `IRMS_LIMITS_RST;
         input_allow_mask <= `IRMS_ALLOW_RST;
         input_rank <= `IRMS_RANK_RST;
         loop_input_choice <= `IRMS_CHOICE_RST;
         los_map_reg <= `IRMS_LOSMAP_RST;
      end
      else if (wr_go)
      begin
         unique case (wb_adr_i)
            `IRMS_ADR_CTRL: ctrl_reg <= 5'(merge(32'(ctrl_reg), wb_dat_i, wb_sel_i));
            `IRMS_ADR_LIMITS: limits_reg <= 20'(merge(32'(limits_reg), wb_dat_i, wb_sel_i));
            `IRMS_ADR_ALLOW:
               input_allow_mask <= 6'(merge(32'(input_allow_mask), wb_dat_i, wb_sel_i));
            `IRMS_ADR_RANK: input_rank <= 24'(merge(32'(input_rank), wb_dat_i, wb_sel_i));
            `IRMS_ADR_CHOICE:
               loop_input_choice <= 12'(merge(32'(loop_input_choice), wb_dat_i, wb_sel_i));
            `IRMS_ADR_LOSMAP: los_map_reg <= 24'(merge(32'(los_map_reg), wb_dat_i, wb_sel_i));
            default: ;
         endcase
      end
   end

   // Sticky flags; a new event beats a same-cycle clear
   always_ff @(posedge clock)
   begin
      for (int l = 0; l < 3; l++)
      begin
         if (srst)
         begin
            change_flag_reg[l] <= 6'h00;
            chosen_ref_failure_flag[l] <= 1'b0;
         end
         else
         begin
            change_flag_reg[l] <= (change_flag_reg[l] & ~clr_chg[8*l +: 6])
                                  | (valid_reg[l] ^ valid_now[l]);
            chosen_ref_failure_flag[l] <= (chosen_ref_failure_flag[l] && !clr_fail[l])
                                          || (bit_at(valid_reg[l], sel_reg[l])
                                              && !bit_at(valid_now[l], sel_reg[l]));
         end
      end
   end

   // Status outputs, all from flops
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         irq <= 1'b0;
         active_input_indicator <= 12'h000;
         top_ranked_usable_input <= 12'h000;
      end
      else
      begin
         irq <= (|change_flag_reg[0]) || (|change_flag_reg[1]) || (|change_flag_reg[2])
                || (|chosen_ref_failure_flag);
         for (int l = 0; l < 3; l++)
         begin
            active_input_indicator[4*l +: 4] <= 4'(sel_next[l]);
            top_ranked_usable_input[4*l +: 4] <= 4'(top_now[l]);
         end
      end
   end

   // Read mux; unmapped addresses read zero
   always_comb
   begin
      rdata = 32'h00000000;
      unique case (wb_adr_i)
         `IRMS_ADR_CTRL: rdata = 32'(ctrl_reg);
         `IRMS_ADR_LIMITS: rdata = 32'(limits_reg);
         `IRMS_ADR_ALLOW: rdata = 32'(input_allow_mask);
         `IRMS_ADR_RANK: rdata = 32'(input_rank);
         `IRMS_ADR_CHOICE: rdata = 32'(loop_input_choice);
         `IRMS_ADR_ALARMS: rdata = {18'h0, input_soft_offset_alarm, 2'h0, input_hard_offset_alarm};
         `IRMS_ADR_OFFS_LO:
            rdata = {offset_value_reg[3], offset_value_reg[2], offset_value_reg[1],
                     offset_value_reg[0]};
         `IRMS_ADR_OFFS_HI: rdata = {16'h0, offset_value_reg[5], offset_value_reg[4]};
         `IRMS_ADR_VALID: rdata = {10'h0, valid_reg[2], 2'h0, valid_reg[1], 2'h0, valid_reg[0]};
         `IRMS_ADR_CHANGE:
            rdata = {10'h0, change_flag_reg[2], 2'h0, change_flag_reg[1], 2'h0,
                     change_flag_reg[0]};
         `IRMS_ADR_FAIL: rdata = {29'h0, chosen_ref_failure_flag};
         `IRMS_ADR_INDIC: rdata = {4'h0, top_ranked_usable_input, 4'h0, active_input_indicator};
         `IRMS_ADR_LOSMAP: rdata = 32'(los_map_reg);
         default: rdata = 32'h00000000;
      endcase
   end

   default clocking dc @(posedge clock); endclocking
   default disable iff (srst);

   a_hard_alarm_set: assert property ((off_now[0] > 12'(thr_ppm(hard_monitor_limits[3:0],
      ppm_scale_factor))) |=> input_hard_offset_alarm[0]) else $error("hard alarm not set");
   a_hard_alarm_hold: assert property (input_hard_offset_alarm[0] && (off_now[0] >=
      12'(thr_ppm(hard_monitor_limits[7:4], ppm_scale_factor))) |=> input_hard_offset_alarm[0])
      else $error("hard alarm dropped early");
   a_soft_alarm_set: assert property ((off_now[1] > 12'(thr_ppm(soft_monitor_limits[3:0],
      ppm_scale_factor))) |=> input_soft_offset_alarm[1]) else $error("soft alarm not set");
   a_hard_blocks_qual: assert property (input_hard_offset_alarm[2] |-> !qual_now[0][2]
      && !qual_now[2][2]) else $error("hard alarm input qualified");
   a_forced_route: assert property (loop_input_choice[3:0] == `IRMS_CODE_F5 |=>
      sel_reg[0] == 3'h5) else $error("forced input not routed");
   a_allow_excludes: assert property (mode_now[1] == irms_pkg::IRMS_AUTO && input_allow_mask[0]
      |=> sel_reg[1] != 3'h1) else $error("disallowed input chosen");
   a_norevert_keep: assert property (mode_now[0] == irms_pkg::IRMS_AUTO
      && !ctrl_reg[`IRMS_CTRL_REVERT1] && bit_at(qual_now[0], sel_reg[0]) |=> $stable(sel_reg[0]))
      else $error("non-revertive switched");
   a_none_avail: assert property (mode_now[2] == irms_pkg::IRMS_AUTO && qual_now[2] == 6'h00
      |=> sel_reg[2] == 3'h0 && active_input_indicator[11:8] == 4'h0)
      else $error("selection without qualified input");
   a_change_irq: assert property (valid_reg[1] != valid_now[1] |=> change_flag_reg[1] != 6'h00
      ##1 irq) else $error("validity change lost");
   a_fail_flag: assert property (bit_at(valid_reg[0], sel_reg[0])
      && !bit_at(valid_now[0], sel_reg[0]) |=> chosen_ref_failure_flag[0])
      else $error("failure not flagged");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
   a_miss_drops: assert property (cycle_miss_check_en && sel_reg[0] == 3'h1
      && in_stat[0].miss_two |-> !valid_now[0][0]) else $error("missing input kept valid");

   c_forced: cover property (mode_now[0] == irms_pkg::IRMS_FORCED ##1 sel_reg[0] != 3'h0);
   c_revert_switch: cover property (mode_now[2] == irms_pkg::IRMS_AUTO && sel_reg[2] != 3'h0
      && top_now[2] != sel_reg[2] ##1 sel_reg[2] == $past(top_now[2]));
   c_failure: cover property (chosen_ref_failure_flag[1]);
   c_change: cover property (change_flag_reg[2] != 6'h00);

endmodule

/* irms_loop_model.sv */
// Far-side model: input monitors and the digital loops behind the selector.
// Assumes the bench sets offsets and alarm causes; one clock domain.
`timescale 1ns/1ps

module irms_loop_model
(
   input wire logic clock,
   input wire logic srst,
   input wire logic [11:0] active_input_indicator,
   input wire logic [5:0][11:0] off_ppm,
   input wire logic [5:0] dead_mask,
   input wire logic [5:0] unlockable,
   input wire logic [5:0] miss_mask,
   output irms_pkg::irms_in_s [5:0] in_stat
);
   logic [5:0] lock_reg;

   // Sticky, like a lock timeout that waits for software
   always_ff @(posedge clock)
   begin
      for (int i = 0; i < 6; i++)
      begin
         if (srst || !unlockable[i])
            lock_reg[i] <= 1'b0;
         else if (active_input_indicator[3:0] == 4'(i + 1) ||
                  active_input_indicator[7:4] == 4'(i + 1))
            lock_reg[i] <= 1'b1;
      end
   end

   // Loop output held on nominal, so its offset reads zero
   always_comb
   begin
      for (int i = 0; i < 6; i++)
      begin
         in_stat[i].dead = dead_mask[i];
         in_stat[i].lock_timeout = lock_reg[i];
         in_stat[i].miss_two = miss_mask[i];
         in_stat[i].off_sys = off_ppm[i];
         in_stat[i].off_loop = 12'h000;
      end
   end
endmodule

/* input_ref_monitor_select_tb.sv */
// Self-checking bench for the input monitor and reference selector.
// Assumes irms_top, irms_loop_model and the shared config header.
`timescale 1ns/1ps
`include "irms_cfg.svh"

module input_ref_monitor_select_tb;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hf;
   logic [31:0] wb_dat_i = 32'h00000000;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic [3:0] los_pins = 4'h0;
   logic [5:0][11:0] off_ppm = 72'h0;
   logic [5:0] dead_mask = 6'h00;
   logic [5:0] unlockable = 6'h00;
   logic [5:0] miss_mask = 6'h00;
   irms_pkg::irms_in_s [5:0] in_stat;
   logic [11:0] active_input_indicator;
   logic [11:0] top_ranked_usable_input;
   logic irq;
   logic [31:0] rdat;
   int errors = 0;
   int total_checks = 0;

   always #20 clock = ~clock;

   irms_top i_irms_top (.clock(clock), .srst(srst), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .in_stat(in_stat), .los_pins(los_pins),
      .active_input_indicator(active_input_indicator),
      .top_ranked_usable_input(top_ranked_usable_input), .irq(irq));

   irms_loop_model i_irms_loop_model (.clock(clock), .srst(srst),
      .active_input_indicator(active_input_indicator), .off_ppm(off_ppm),
      .dead_mask(dead_mask), .unlockable(unlockable), .miss_mask(miss_mask),
      .in_stat(in_stat));

   task automatic results;
      if (errors == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask

   // Holds the request until ack is seen; no fixed latency assumed
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      @(posedge clock);
      while (wb_ack_o !== 1'b1 && n < 50)
      begin
         @(posedge clock);
         n++;
      end
      if (n == 50)
         chk(32'h00000000, 32'h00000001);
      rdat = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clock);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h00000000);
      chk(rdat, exp);
   endtask

   task automatic settle;
      repeat (5) @(posedge clock);
   endtask

   task automatic ind(input logic [11:0] act, input logic [11:0] top);
      settle;
      rd(`IRMS_ADR_INDIC, {4'h0, top, 4'h0, act});
      chk({20'h0, active_input_indicator}, {20'h0, act});
      chk({20'h0, top_ranked_usable_input}, {20'h0, top});
   endtask

   task automatic clr;
      wr(`IRMS_ADR_CHANGE, 32'hffffffff);
      wr(`IRMS_ADR_FAIL, 32'h00000007);
   endtask

   task automatic t_reset;
      rd(`IRMS_ADR_ALLOW, 32'h0000003f);
      ind(12'h000, 12'h000);
      wr(`IRMS_ADR_INDIC, 32'hffffffff);
      rd(`IRMS_ADR_INDIC, 32'h00000000);
      wr(8'h40, 32'hffffffff);
      rd(8'h40, 32'h00000000);
   endtask

   task automatic t_hyst;
      logic [11:0] offs [6] = '{12'h00a, 12'h00b, 12'h004, 12'h00f, 12'h008, 12'h003};
      logic [31:0] alm [6] = '{32'h0, 32'h1, 32'h1, 32'h101, 32'h101, 32'h0};
      // Factor 2: hard accept 4, reject 10; soft accept 8, reject 14
      wr(`IRMS_ADR_LIMITS, 32'h00023614);
      for (int k = 0; k < 6; k++)
      begin
         off_ppm[0] <= offs[k];
         settle;
         rd(`IRMS_ADR_ALARMS, alm[k]);
         rd(`IRMS_ADR_OFFS_LO, {24'h0, offs[k][8:1]});
      end
      off_ppm[0] <= 12'h00f;
      // Noise window set as software must for slow inputs; stored only
      wr(`IRMS_ADR_CTRL, 32'h00000011);
      rd(`IRMS_ADR_CTRL, 32'h00000011);
      settle;
      rd(`IRMS_ADR_ALARMS, 32'h00000000);
      // Offset back to zero first, so no alarm flickers on the switch back
      off_ppm[0] <= 12'h000;
      wr(`IRMS_ADR_CTRL, 32'h00000000);
   endtask

   task automatic t_auto;
      wr(`IRMS_ADR_RANK, 32'h00000351);
      wr(`IRMS_ADR_CTRL, 32'h0000000c);
      wr(`IRMS_ADR_ALLOW, 32'h00000038);
      ind(12'h222, 12'h222);
      clr;
      off_ppm[1] <= 12'h014;
      ind(12'h333, 12'h333);
      rd(`IRMS_ADR_FAIL, 32'h00000007);
      rd(`IRMS_ADR_CHANGE, 32'h00020202);
      chk({31'h0, irq}, 32'h00000001);
      clr;
      settle;
      chk({31'h0, irq}, 32'h00000000);
      off_ppm[1] <= 12'h000;
      ind(12'h222, 12'h222);
      wr(`IRMS_ADR_CTRL, 32'h00000008);
      off_ppm[1] <= 12'h014;
      ind(12'h333, 12'h333);
      off_ppm[1] <= 12'h000;
      ind(12'h223, 12'h222);
      dead_mask <= 6'h04;
      ind(12'h222, 12'h222);
      dead_mask <= 6'h00;
      wr(`IRMS_ADR_LOSMAP, 32'h00000010);
      los_pins <= 4'h1;
      ind(12'h333, 12'h333);
      los_pins <= 4'h0;
      wr(`IRMS_ADR_ALLOW, 32'h0000003f);
      ind(12'h000, 12'h000);
      wr(`IRMS_ADR_LOSMAP, 32'h00000000);
      clr;
   endtask

   task automatic t_forced;
      logic [3:0] code [9] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h9, 4'ha, 4'h1, 4'h7, 4'hb};
      logic [3:0] want [9] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h0, 4'h0, 4'h0};
      // Every input dead: only forcing can route anything
      dead_mask <= 6'h3f;
      for (int k = 0; k < 9; k++)
      begin
         wr(`IRMS_ADR_CHOICE, {20'h0, code[k], code[k], code[k]});
         ind({want[k], want[k], want[k]}, 12'h000);
      end
      wr(`IRMS_ADR_CHOICE, 32'h00000000);
      dead_mask <= 6'h00;
   endtask

   task automatic t_lock;
      wr(`IRMS_ADR_RANK, 32'h00000015);
      wr(`IRMS_ADR_CTRL, 32'h0000000c);
      wr(`IRMS_ADR_ALLOW, 32'h0000003c);
      ind(12'h111, 12'h111);
      unlockable <= 6'h01;
      ind(12'h122, 12'h122);
      unlockable <= 6'h00;
      ind(12'h111, 12'h111);
      // Missing input 1: ignored until the check bit is set
      miss_mask <= 6'h01;
      ind(12'h111, 12'h111);
      clr;
      // Non-revertive, so loops one, two do not bounce back to input 1
      wr(`IRMS_ADR_CTRL, 32'h00000002);
      ind(12'h122, 12'h111);
      rd(`IRMS_ADR_FAIL, 32'h00000003);
      miss_mask <= 6'h00;
   endtask

   initial
   begin
      repeat (3) @(posedge clock);
      srst <= 1'b0;
      @(posedge clock);
      t_reset;
      t_hyst;
      t_auto;
      t_forced;
      t_lock;
      results;
   end

   // Whole sequence needs well under 2000 cycles
   initial
   begin
      repeat (20000) @(posedge clock);
      errors++;
      results;
   end
endmodule
